// ---- tkc2_filter.sv ----
/*
 * tkc2_filter: comparator glitch filter; output high only when the last
 * n samples, one per oscillator tick, were all ones.
 * assumes osc_tick is a one-cycle pulse in ref_clk domain.
 */
`timescale 1ns/1ps
module tkc2_filter
    import tkc2_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // sampling
    input  wire logic       osc_tick,
    input  wire logic       clear,
    input  wire logic       cmp_in,
    input  wire logic [3:0] filter_len,
    // result
    output logic            filt_out
);
    logic [3:0] run_r;

    // run length of consecutive ones, saturating at 15
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            run_r <= 4'h0;
        end else if (clear) begin
            run_r <= 4'h0;
        end else if (osc_tick) begin
            if (!cmp_in) begin
                run_r <= 4'h0;
            end else if (run_r != 4'hf) begin
                run_r <= run_r + 4'h1;
            end
        end
    end

    // a zero length is treated as one: the field is only valid from 1
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            filt_out <= 1'b0;
        end else begin
            filt_out <= (run_r >= ((filter_len == 4'h0) ? 4'h1 : filter_len)) && !clear;
        end
    end
endmodule

// ---- tkc2_pad_model.sv ----
/* tkc2_pad_model: reference capacitor and comparator as seen from the pads.
   assumes pad_ctl levels; the oscillator tick runs free, every other cycle. */
`timescale 1ns/1ps
module tkc2_pad_model
    import tkc2_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // pads and threshold
    input  wire tkc2_pad_t  pad_ctl,
    input  wire logic [7:0] trip_dumps,
    // comparator and oscillator tick
    output logic            cmp_in,
    output logic            osc_tick
);
    logic [7:0] dumps_r;
    logic       dump_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dumps_r  <= 8'h00;
            dump_q   <= 1'b0;
            osc_tick <= 1'b0;
        end else begin
            dump_q   <= pad_ctl.dump_sw;
            osc_tick <= ~osc_tick;
            if (pad_ctl.zero_switch) begin
                dumps_r <= 8'h00;
            end else if (pad_ctl.dump_sw && !dump_q) begin
                dumps_r <= dumps_r + 8'h01;
            end
        end
    end
    // crosses the threshold once enough charge packets landed, so a slow key is a larger trip
    assign cmp_in = !pad_ctl.zero_switch && dumps_r >= trip_dumps;
endmodule

// ---- tkc2_pkg.sv ----
/*
 * tkc2_pkg: register offsets, field positions, reset values, timing constants
 * and carrier structs for the switched-capacitance touch-key cycle counter.
 * assumes an 8-bit register port with byte-wide registers at printed offsets.
 */
package tkc2_pkg;

    // register addresses
    localparam logic [15:0] TKC2_ADDR_CFG  = 16'ha150;
    localparam logic [15:0] TKC2_ADDR_ZFC  = 16'ha151;
    localparam logic [15:0] TKC2_ADDR_CMD  = 16'ha152;
    localparam logic [15:0] TKC2_ADDR_CNTL = 16'ha153;
    localparam logic [15:0] TKC2_ADDR_CNTH = 16'ha154;
    localparam logic [15:0] TKC2_ADDR_ISTS = 16'ha155;
    localparam logic [15:0] TKC2_ADDR_IMSK = 16'ha156;

    localparam logic [7:0] TKC2_RST_BYTE = 8'h00;

    // primary configuration fields
    localparam int TKC2_CFG_EN_BIT = 7;
    localparam int TKC2_CFG_CD_LSB = 0;

    // zero/filter config fields
    localparam int TKC2_ZFC_PD_BIT   = 7;
    localparam int TKC2_ZFC_ZERO_LSB = 4;
    localparam int TKC2_ZFC_FIL_LSB  = 0;

    // command/irq fields
    localparam int TKC2_CMD_IEN_BIT   = 7;
    localparam int TKC2_CMD_MSB_LSB   = 5;
    localparam int TKC2_CMD_SHIFT_BIT = 4;
    localparam int TKC2_CMD_RPT_LSB   = 2;
    localparam int TKC2_CMD_FLAG_BIT  = 1;
    localparam int TKC2_CMD_START_BIT = 0;

    // timing: zero phase is lead + 128*(zero+1) + tail system clock periods
    localparam int TKC2_ZERO_LEAD_CYC = 4;
    localparam int TKC2_ZERO_UNIT_CYC = 128;
    localparam int TKC2_ZERO_TAIL_CYC = 1;
    localparam int TKC2_CNT_W         = 18;
    localparam int TKC2_TMR_W         = 11;

    // status bit positions (sticky events)
    localparam int TKC2_EV_DONE = 0;
    localparam int TKC2_EV_OVF  = 1;

    typedef enum logic [2:0] {
        TKC2_IDLE,
        TKC2_ZERO,
        TKC2_CHARGE,
        TKC2_DUMP,
        TKC2_DONE
    } tkc2_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } tkc2_bus_req_t;

    typedef struct packed {
        logic pad_pulldown;
        logic zero_switch;
        logic charge_sw;
        logic dump_sw;
    } tkc2_pad_t;

endpackage

// ---- tkc2_seq.sv ----
/*
 * tkc2_seq: touch-key cycle counter sequencer with its register port.
 * assumes a synchronous comparator input and an oscillator tick pulse
 * already in the ref_clk domain; the analogue front end is outside.
 */
// Decided for this implementation: the address-and-strobe port.
//
// Behaviour
// - pad pulldown on for (zero+1)*128 cycles
// - zero phase lasts 4+128*(zero+1)+1 cycles
// - filter asserts after N consecutive one samples
// - repeat field selects 1,2,4,8 conversions
// - flag set at completion, software clears
// - counter cleared on start, holds total, or total >> repeat code when shift is set
// - charge-dump cycles counted until the filter output is high at a dump end
// - each charge and dump phase lasts charge_dump_time+1 cycles
// - sequencer runs only when controller enabled
`timescale 1ns/1ps
module tkc2_seq
    import tkc2_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // analogue front end
    input  wire logic        cmp_in,
    input  wire logic        osc_tick,
    output tkc2_pad_t        pad_ctl,
    // interrupt
    output logic             irq
);
    tkc2_bus_req_t req;
    tkc2_state_t   state_r;
    logic [7:0]    cfg_r;
    logic [7:0]    zfc_r;
    logic          ien_r;
    logic          shift_r;
    logic [1:0]    rpt_r;
    logic          flag_r;
    logic          busy_r;
    logic [1:0]    ists_r;
    logic [1:0]    imsk_r;
    logic [TKC2_CNT_W-1:0] cnt_r;
    logic [TKC2_CNT_W-1:0] cnt_nxt;
    logic [TKC2_TMR_W-1:0] tmr_r;
    logic [3:0]    conv_r;
    logic          filt;
    logic          filt_clr;
    logic          enable;
    logic          start_req;
    logic          done_ev;
    logic          ovf_ev;
    logic [2:0]    zero_len;
    logic [3:0]    cd_len;
    logic [TKC2_TMR_W-1:0] zero_total;
    logic [TKC2_TMR_W-1:0] pd_total;

    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;

    // one-hot conversion count from the two-bit code
    function automatic logic [3:0] rpt_num(input logic [1:0] code);
        rpt_num = 4'h1 << code;
    endfunction

    function automatic logic wr_hit(input tkc2_bus_req_t r, input logic [15:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction

    assign enable     = cfg_r[TKC2_CFG_EN_BIT];
    assign zero_len   = zfc_r[TKC2_ZFC_ZERO_LSB +: 3];
    assign cd_len     = cfg_r[TKC2_CFG_CD_LSB +: 4];
    assign zero_total = TKC2_TMR_W'(TKC2_ZERO_LEAD_CYC + TKC2_ZERO_UNIT_CYC * (int'(zero_len) + 1)
                        + TKC2_ZERO_TAIL_CYC);
    assign pd_total   = TKC2_TMR_W'(TKC2_ZERO_UNIT_CYC * (int'(zero_len) + 1));
    assign start_req  = wr_hit(req, TKC2_ADDR_CMD) && req.wdata[TKC2_CMD_START_BIT]
                        && enable && !busy_r;
    assign filt_clr   = (state_r != TKC2_CHARGE) && (state_r != TKC2_DUMP);

    tkc2_filter u_filter (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .osc_tick   (osc_tick),
        .clear      (filt_clr),
        .cmp_in     (cmp_in),
        .filter_len (zfc_r[TKC2_ZFC_FIL_LSB +: 4]),
        .filt_out   (filt)
    );

    // configuration registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= TKC2_RST_BYTE;
            zfc_r <= TKC2_RST_BYTE;
        end else begin
            if (wr_hit(req, TKC2_ADDR_CFG)) begin
                cfg_r <= req.wdata;
            end
            if (wr_hit(req, TKC2_ADDR_ZFC)) begin
                zfc_r <= req.wdata;
            end
        end
    end

    // command fields; repeat and shift are frozen while busy
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ien_r   <= 1'b0;
            shift_r <= 1'b0;
            rpt_r   <= 2'h0;
            imsk_r  <= 2'h0;
        end else begin
            if (wr_hit(req, TKC2_ADDR_CMD)) begin
                ien_r <= req.wdata[TKC2_CMD_IEN_BIT];
                if (!busy_r) begin
                    shift_r <= req.wdata[TKC2_CMD_SHIFT_BIT];
                    rpt_r   <= req.wdata[TKC2_CMD_RPT_LSB +: 2];
                end
            end
            if (wr_hit(req, TKC2_ADDR_IMSK)) begin
                imsk_r <= req.wdata[1:0];
            end
        end
    end

    // interrupt flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flag_r <= 1'b0;
        end else if (done_ev) begin
            flag_r <= 1'b1;
        end else if (wr_hit(req, TKC2_ADDR_CMD) && !req.wdata[TKC2_CMD_FLAG_BIT]) begin
            flag_r <= 1'b0;
        end
    end

    // sticky event status, write one to clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ists_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == TKC2_EV_DONE && done_ev) || (i == TKC2_EV_OVF && ovf_ev)) begin
                    ists_r[i] <= 1'b1;
                end else if (wr_hit(req, TKC2_ADDR_ISTS) && req.wdata[i]) begin
                    ists_r[i] <= 1'b0;
                end
            end
        end
    end

    assign irq = (flag_r && ien_r) || |(ists_r & imsk_r);

    // sequencer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= TKC2_IDLE;
            tmr_r   <= '0;
            conv_r  <= 4'h0;
            busy_r  <= 1'b0;
        end else if (!enable) begin
            state_r <= TKC2_IDLE;
            tmr_r   <= '0;
            conv_r  <= 4'h0;
            busy_r  <= 1'b0;
        end else begin
            case (state_r)
                TKC2_IDLE: begin
                    if (start_req) begin
                        state_r <= TKC2_ZERO;
                        tmr_r   <= '0;
                        conv_r  <= 4'h0;
                        busy_r  <= 1'b1;
                    end
                end
                TKC2_ZERO: begin
                    if (tmr_r == zero_total - TKC2_TMR_W'(1)) begin
                        state_r <= TKC2_CHARGE;
                        tmr_r   <= '0;
                    end else begin
                        tmr_r <= tmr_r + TKC2_TMR_W'(1);
                    end
                end
                TKC2_CHARGE: begin
                    if (tmr_r == TKC2_TMR_W'(cd_len)) begin
                        state_r <= TKC2_DUMP;
                        tmr_r   <= '0;
                    end else begin
                        tmr_r <= tmr_r + TKC2_TMR_W'(1);
                    end
                end
                TKC2_DUMP: begin
                    if (tmr_r == TKC2_TMR_W'(cd_len)) begin
                        tmr_r <= '0;
                        if (filt) begin
                            if (conv_r + 4'h1 == rpt_num(rpt_r)) begin
                                state_r <= TKC2_DONE;
                            end else begin
                                conv_r  <= conv_r + 4'h1;
                                state_r <= TKC2_ZERO;
                            end
                        end else begin
                            state_r <= TKC2_CHARGE;
                        end
                    end else begin
                        tmr_r <= tmr_r + TKC2_TMR_W'(1);
                    end
                end
                TKC2_DONE: begin
                    state_r <= TKC2_IDLE;
                    busy_r  <= 1'b0;
                end
                default: begin
                    state_r <= TKC2_IDLE;
                    busy_r  <= 1'b0;
                end
            endcase
        end
    end

    assign done_ev = (state_r == TKC2_DONE);

    // a counted cycle ends at the dump edge; saturate rather than wrap
    assign ovf_ev = (state_r == TKC2_DUMP) && (tmr_r == TKC2_TMR_W'(cd_len)) && (&cnt_r);

    always_comb begin
        cnt_nxt = cnt_r;
        if (state_r == TKC2_DUMP && tmr_r == TKC2_TMR_W'(cd_len) && !(&cnt_r)) begin
            cnt_nxt = cnt_r + TKC2_CNT_W'(1);
        end else if (state_r == TKC2_DONE && shift_r) begin
            cnt_nxt = cnt_r >> rpt_r;
        end
    end

    // count: cleared by start, software may also preload the low bytes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else if (start_req) begin
            cnt_r <= '0;
        end else if (busy_r) begin
            cnt_r <= cnt_nxt;
        end else if (wr_hit(req, TKC2_ADDR_CNTL)) begin
            cnt_r[7:0] <= req.wdata;
        end else if (wr_hit(req, TKC2_ADDR_CNTH)) begin
            cnt_r[15:8] <= req.wdata;
        end
    end

    // pad controls; pulldown covers the first part of the zero phase only
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pad_ctl <= '0;
        end else begin
            pad_ctl.zero_switch  <= (state_r == TKC2_ZERO);
            pad_ctl.pad_pulldown <= (state_r == TKC2_ZERO) && zfc_r[TKC2_ZFC_PD_BIT]
                                    && (tmr_r < pd_total);
            pad_ctl.charge_sw    <= (state_r == TKC2_CHARGE);
            pad_ctl.dump_sw      <= (state_r == TKC2_DUMP);
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= TKC2_RST_BYTE;
        end else if (req.rd) begin
            case (req.addr)
                TKC2_ADDR_CFG:  reg_rdata <= cfg_r;
                TKC2_ADDR_ZFC:  reg_rdata <= zfc_r;
                TKC2_ADDR_CMD:  reg_rdata <= {ien_r, cnt_r[17:16], shift_r, rpt_r, flag_r, busy_r};
                TKC2_ADDR_CNTL: reg_rdata <= cnt_r[7:0];
                TKC2_ADDR_CNTH: reg_rdata <= cnt_r[15:8];
                TKC2_ADDR_ISTS: reg_rdata <= {6'h00, ists_r};
                TKC2_ADDR_IMSK: reg_rdata <= {6'h00, imsk_r};
                default:        reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// ---- tkc2_seq_props.sv ----
/* tkc2_seq_props: port-level checks of the touch-key sequencer.
   assumes it is bound to tkc2_seq and config is written only while idle. */
`timescale 1ns/1ps
module tkc2_seq_props
    import tkc2_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // front end and interrupt
    input wire logic        cmp_in,
    input wire logic        osc_tick,
    input wire tkc2_pad_t   pad_ctl,
    input wire logic        irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic [7:0]       cfg_r;
    logic [7:0]       zfc_r;
    logic [3:0][10:0] run_r;
    int               zunit;
    assign zunit = 128 * (int'(zfc_r[6:4]) + 1);
    // shadow of the config bytes, seen from the bus writes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= 8'h00;
            zfc_r <= 8'h00;
        end else if (reg_wr && reg_addr == TKC2_ADDR_CFG) begin
            cfg_r <= reg_wdata;
        end else if (reg_wr && reg_addr == TKC2_ADDR_ZFC) begin
            zfc_r <= reg_wdata;
        end
    end
    // length of the current run of each switch; still holds it when the switch falls
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            run_r <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                run_r[i] <= pad_ctl[i] ? run_r[i] + 11'h1 : 11'h0;
            end
        end
    end
    a_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_zero_len: assert property ($fell(pad_ctl.zero_switch) && cfg_r[7] |-> run_r[2] == 11'(zunit + 5))
        else $error("zero phase length");
    a_pd_len: assert property ($fell(pad_ctl.pad_pulldown) && cfg_r[7] |-> run_r[3] == 11'(zunit))
        else $error("pulldown length");
    a_pd_start: assert property ($rose(pad_ctl.zero_switch) |-> pad_ctl.pad_pulldown == zfc_r[7])
        else $error("pulldown start");
    a_pd_inside: assert property (pad_ctl.pad_pulldown |-> pad_ctl.zero_switch)
        else $error("pulldown outside zeroing");
    a_charge_len: assert property ($fell(pad_ctl.charge_sw) && cfg_r[7] |-> run_r[1] == 11'(cfg_r[3:0]) + 11'h1)
        else $error("charge length");
    a_dump_len: assert property ($fell(pad_ctl.dump_sw) && cfg_r[7] |-> run_r[0] == 11'(cfg_r[3:0]) + 11'h1)
        else $error("dump length");
    a_charge_dump: assert property ($fell(pad_ctl.charge_sw) && cfg_r[7] |-> pad_ctl.dump_sw)
        else $error("no dump after charge");
    a_zero_charge: assert property ($fell(pad_ctl.zero_switch) && cfg_r[7] |-> pad_ctl.charge_sw)
        else $error("no charge after zeroing");
endmodule

// ---- tkc2_seq_tb.sv ----
/* tkc2_seq_tb: register-level tests of the touch-key sequencer.
   assumes the pad model as far side and a 100 MHz ref_clk. */
`timescale 1ns/1ps
bind tkc2_seq tkc2_seq_props u_props (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_in(cmp_in), .osc_tick(osc_tick),
    .pad_ctl(pad_ctl), .irq(irq));
module tkc2_seq_tb
    import tkc2_pkg::*;
;
    logic             ref_clk = 1'b0;
    logic             rstn = 1'b0;
    logic [15:0]      reg_addr = 16'h0000;
    logic [7:0]       reg_wdata = 8'h00;
    logic             reg_wr = 1'b0;
    logic             reg_rd = 1'b0;
    logic [7:0]       reg_rdata;
    logic             cmp_in;
    logic             osc_tick;
    tkc2_pad_t        pad_ctl;
    logic             irq;
    logic [7:0]       trip = 8'h03;
    logic [15:0]      a;
    logic [7:0]       d;
    logic [3:0][10:0] run = '0;
    logic [3:0][10:0] last = '0;
    int               fail_count = 0;
    int               num_checks = 0;
    int               cyc = 0;
    always #5 ref_clk = ~ref_clk;
    tkc2_seq dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_in(cmp_in), .osc_tick(osc_tick), .pad_ctl(pad_ctl), .irq(irq));
    tkc2_pad_model u_pad (.ref_clk(ref_clk), .rstn(rstn), .pad_ctl(pad_ctl), .trip_dumps(trip), .cmp_in(cmp_in),
        .osc_tick(osc_tick));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // last completed run length of each pad switch; the run is far longer than any test
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            end_of_test();
        end
        for (int i = 0; i < 4; i++) begin
            run[i] <= pad_ctl[i] ? run[i] + 11'h1 : 11'h0;
            if (!pad_ctl[i] && run[i] != 11'h0) last[i] <= run[i];
        end
    end
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] ad, input logic [7:0] v);
        reg_addr  <= ad;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [15:0] ad, output logic [7:0] v);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge ref_clk);
    endtask
    // one measurement with repeat code r; zero field follows r, trip grows with r
    // filter length f is 2, or 3 to 10: a slow filter misses the trip dump and adds one dump per conversion
    task automatic conv(input logic [1:0] r, input logic s, input logic [3:0] f);
        logic [7:0]  v;
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [17:0] exp;
        exp = 18'(((3 + int'(r) + ((f > 4'h2) ? 1 : 0)) << r) >> (s ? r : 2'd0));
        trip <= 8'h03 + 8'(r);
        wr(TKC2_ADDR_ZFC, {2'b10, r, f});
        wr(TKC2_ADDR_CNTL, 8'h55);
        wr(TKC2_ADDR_CMD, {3'b100, s, r, 2'b01});
        rd(TKC2_ADDR_CMD, v);
        chk(18'(v[0]), 18'h1);
        for (int n = 0; n < 4000 && v[0] !== 1'b0; n++) rd(TKC2_ADDR_CMD, v);
        chk(18'(v[1:0]), 18'h2);
        chk(18'(irq), 18'h1);
        rd(TKC2_ADDR_CNTL, lo);
        rd(TKC2_ADDR_CNTH, hi);
        chk({v[6:5], hi, lo}, exp);
        chk(18'(last[2]), 18'(128 * (int'(r) + 1) + 5));
        chk(18'(last[3]), 18'(128 * (int'(r) + 1)));
        chk(18'(last[1]), 18'h8);
        chk(18'(last[0]), 18'h8);
        wr(TKC2_ADDR_CMD, 8'h80);
        chk(18'(irq), 18'h0);
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        chk(18'(irq), 18'h0);
        // reset values, plus one unmapped address
        for (a = TKC2_ADDR_CFG; a <= 16'ha157; a++) begin
            rd(a, d);
            chk(18'(d), 18'h0);
        end
        wr(TKC2_ADDR_CNTH, 8'ha5);
        rd(TKC2_ADDR_CNTH, d);
        chk(18'(d), 18'ha5);
        wr(TKC2_ADDR_CMD, 8'h01);
        rd(TKC2_ADDR_CMD, d);
        chk(18'(d[0]), 18'h0);
        wr(TKC2_ADDR_CFG, 8'h87);
        for (int i = 0; i < 4; i++) conv(2'(i), 1'b0, 4'h2);
        conv(2'd3, 1'b1, 4'h6);
        rd(TKC2_ADDR_ISTS, d);
        chk(18'(d[0]), 18'h1);
        wr(TKC2_ADDR_IMSK, 8'h01);
        chk(18'(irq), 18'h1);
        wr(TKC2_ADDR_ISTS, 8'h01);
        rd(TKC2_ADDR_ISTS, d);
        chk({17'h0, d[0] | irq}, 18'h0);
        // zeroing with the pulldown off, then a disable in mid-zeroing must abort without a flag
        wr(TKC2_ADDR_ZFC, 8'h02);
        wr(TKC2_ADDR_CMD, 8'h01);
        repeat (50) @(posedge ref_clk);
        wr(TKC2_ADDR_CFG, 8'h07);
        rd(TKC2_ADDR_CMD, d);
        chk(18'(d[1:0]), 18'h0);
        end_of_test();
    end
endmodule
